// file: include/frpe_pkg.sv
// Constants for the flash row program / block erase sequencer.
// Assumes a 32-bit Avalon-MM register slave and a 10 MHz system clock.
// Functional notes
// - Program one row at a time; erase acts on eight consecutive rows.
// - Control bits 3:0 select operation: 0010 block erase, 0001 row program.
// - No erase or program proceeds without the unlock key sequence.
// - Start bit 15 begins the selected cycle; CPU stalls throughout.
// - Start bit clears itself when the cycle completes.
// - Row program takes 64 instructions from holding buffers loaded first.
package frpe_pkg;
   // Register word byte addresses
   localparam logic [3:0]  FRPE_CTRL_OFS      = 4'h0;
   localparam logic [3:0]  FRPE_KEY_OFS       = 4'h4;
   localparam logic [3:0]  FRPE_PAGE_OFS      = 4'h8;
   localparam logic [3:0]  FRPE_OFFS_OFS      = 4'hC;
   // Control register fields
   localparam int          FRPE_OP_LSB        = 0;
   localparam int          FRPE_OP_W          = 4;
   localparam int          FRPE_ERASE_BIT     = 6;
   localparam int          FRPE_ERR_BIT       = 13;
   localparam int          FRPE_PROGRAM_WRITE_ENABLE_BIT      = 14;
   localparam int          FRPE_START_BIT     = 15;
   localparam logic [15:0] FRPE_CTRL_RST      = 16'h0000;
   // Operation codes and keys
   localparam logic [3:0]  FRPE_OP_ERASE      = 4'h2;
   localparam logic [3:0]  FRPE_OP_ROW        = 4'h1;
   localparam logic [7:0]  FRPE_KEY1          = 8'h55;
   localparam logic [7:0]  FRPE_KEY2          = 8'hAA;
   // Geometry
   localparam int          FRPE_ROW_WORDS     = 64;
   localparam int          FRPE_BLK_ROWS      = 8;
   // Cycle times in microseconds, converted at the 10 MHz rate
   localparam int          FRPE_CLK_MHZ       = 10;
   localparam int          FRPE_ERASE_US      = 400;
   localparam int          FRPE_ROW_US        = 200;
   localparam int          FRPE_ERASE_CYC     = FRPE_ERASE_US * FRPE_CLK_MHZ;
   localparam int          FRPE_ROW_CYC       = FRPE_ROW_US * FRPE_CLK_MHZ;
endpackage

// file: core/frpe_unlock.sv
// Unlock key tracker for the flash sequencer.
// Assumes one-cycle pulses for each accepted bus write.
`timescale 1ns/1ps
`default_nettype none
module frpe_unlock
   import frpe_pkg::*;
(
   input  wire logic       i_ref_clk,
   input  wire logic       i_reset_n,
   input  wire logic       i_key_wr,
   input  wire logic [7:0] i_key_data,
   input  wire logic       i_other_wr,
   output logic            o_armed
);
   typedef enum logic [1:0] {FRPE_IDLE, FRPE_GOT55, FRPE_ARMED} frpe_key_t;
   frpe_key_t state_q;
   frpe_key_t state_d;

   // Any write other than the next key breaks the sequence
   always_comb begin
      state_d = state_q;
      if (i_key_wr) begin
         if (i_key_data == FRPE_KEY1) begin
            state_d = FRPE_GOT55;
         end else if (i_key_data == FRPE_KEY2 && state_q == FRPE_GOT55) begin
            state_d = FRPE_ARMED;
         end else begin
            state_d = FRPE_IDLE;
         end
      end else if (i_other_wr) begin
         state_d = FRPE_IDLE;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) state_q <= FRPE_IDLE;
      else            state_q <= state_d;
   end

   assign o_armed = (state_q == FRPE_ARMED);

   key_order_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      $rose(o_armed) |-> $past(i_key_wr) && $past(i_key_data) == FRPE_KEY2)
      else $error("armed without AA key");
endmodule
`default_nettype wire

// file: core/frpe_timer.sv
// Down counter that times one erase or row program cycle.
// Assumes a one-cycle load pulse; done pulses once at the end.
`timescale 1ns/1ps
`default_nettype none
module frpe_timer #(
   parameter int W = 16
) (
   input  wire logic         i_ref_clk,
   input  wire logic         i_reset_n,
   input  wire logic         i_load,
   input  wire logic [W-1:0] i_count,
   output logic              o_busy,
   output logic              o_done
);
   logic [W-1:0] cnt_q;
   logic         busy_q;
   logic         done_q;
   wire          last = busy_q && (cnt_q == W'(1));

   // Count is the full cycle length; done follows the last busy cycle
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_q  <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= last;
         if (i_load) begin
            cnt_q  <= i_count;
            busy_q <= 1'b1;
         end else if (busy_q) begin
            cnt_q  <= cnt_q - W'(1);
            busy_q <= !last;
         end
      end
   end
   assign o_busy = busy_q;
   assign o_done = done_q;
endmodule
`default_nettype wire

// file: core/frpe_top.sv
// Flash row program / block erase sequencer with Avalon-MM registers.
// Assumes a flash array outside that takes one erase or row program
// command and the holding buffer contents; the CPU honours o_cpu_stall.
`timescale 1ns/1ps
`default_nettype none
module frpe_top
   import frpe_pkg::*;
#(
   parameter int ERASE_CYC = FRPE_ERASE_CYC,
   parameter int ROW_CYC   = FRPE_ROW_CYC,
   parameter int ROW_WORDS = FRPE_ROW_WORDS,
   parameter int IW        = 24
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset_n,
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   input  wire logic        i_buf_wr,
   input  wire logic [5:0]  i_buf_idx,
   input  wire logic [IW-1:0] i_buf_data,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   output logic [1:0]       o_avs_response,
   output logic             o_cpu_stall,
   output logic             o_flash_erase,
   output logic             o_flash_row,
   output logic [23:0]      o_flash_addr,
   output logic [5:0]       o_flash_idx,
   output logic [IW-1:0]    o_flash_data,
   output logic             o_flash_data_vld
);
   localparam int TW = $clog2(ERASE_CYC > ROW_CYC ? ERASE_CYC + 1 : ROW_CYC + 1);

   // Holding buffers filled by table writes before a row program
   logic [IW-1:0] hold_mem [ROW_WORDS];

   logic [15:0] ctrl_q;
   logic [7:0]  page_q;
   logic [15:0] offs_q;
   logic        ack_q;
   logic [31:0] rdata_q;
   logic [1:0]  resp_q;
   logic        stall_q;
   logic        erase_q;
   logic        row_q;
   logic [23:0] faddr_q;
   logic [5:0]  fidx_q;
   logic [IW-1:0] fdata_q;
   logic        fvld_q;
   logic        streaming_q;
   logic        armed;
   logic        t_busy;
   logic        t_done;

   // Bus decode; a request answers in the cycle after it is seen
   wire req      = (i_avs_read | i_avs_write) & ~ack_q;
   wire wr       = i_avs_write & ~ack_q & i_avs_byteenable[0];
   wire hit_ctrl = (i_avs_address == FRPE_CTRL_OFS);
   wire hit_key  = (i_avs_address == FRPE_KEY_OFS);
   wire hit_page = (i_avs_address == FRPE_PAGE_OFS);
   wire hit_offs = (i_avs_address == FRPE_OFFS_OFS);
   wire mapped   = hit_ctrl | hit_key | hit_page | hit_offs;
   wire key_wr   = wr & hit_key;
   wire other_wr = wr & ~hit_key;
   wire [15:0] wdat  = i_avs_writedata[15:0];
   wire [3:0]  op    = wdat[FRPE_OP_LSB +: FRPE_OP_W];
   wire op_erase = (op == FRPE_OP_ERASE) & wdat[FRPE_ERASE_BIT];
   wire op_row   = (op == FRPE_OP_ROW) & ~wdat[FRPE_ERASE_BIT];
   wire op_ok    = wdat[FRPE_PROGRAM_WRITE_ENABLE_BIT] & (op_erase | op_row);
   wire start_req = wr & hit_ctrl & wdat[FRPE_START_BIT] & ~t_busy;
   wire start_ok  = start_req & armed & op_ok;
   wire start_bad = start_req & ~start_ok;
   wire [TW-1:0] cyc = op_erase ? TW'(ERASE_CYC) : TW'(ROW_CYC);
   // Erase addresses align down to an eight-row boundary
   wire [23:0] tgt   = {page_q, offs_q};
   wire [23:0] blk   = {tgt[23:10], 10'h000};
   wire [23:0] rowa  = {tgt[23:7], 7'h00};
   wire ctrl_wr_cfg = wr & hit_ctrl & ~t_busy;
   wire [31:0] rd_mux = hit_ctrl ? {16'h0000, ctrl_q} :
                        hit_page ? {24'h000000, page_q} :
                        hit_offs ? {16'h0000, offs_q} : 32'h0000_0000;

   frpe_unlock u_unlock (
      .i_ref_clk  (i_ref_clk),
      .i_reset_n  (i_reset_n),
      .i_key_wr   (key_wr),
      .i_key_data (wdat[7:0]),
      .i_other_wr (other_wr),
      .o_armed    (armed)
   );

   frpe_timer #(.W(TW)) u_timer (
      .i_ref_clk (i_ref_clk),
      .i_reset_n (i_reset_n),
      .i_load    (start_ok),
      .i_count   (cyc),
      .o_busy    (t_busy),
      .o_done    (t_done)
   );

   // Holding buffer writes are refused while the cycle timer is busy
   always_ff @(posedge i_ref_clk) begin
      if (i_buf_wr && !t_busy) hold_mem[i_buf_idx] <= i_buf_data;
   end

   // Bus slave: one wait state, then a single-cycle acknowledge
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0000_0000;
         resp_q  <= 2'h0;
      end else begin
         ack_q   <= req;
         rdata_q <= req ? rd_mux : 32'h0000_0000;
         resp_q  <= (req && !mapped) ? 2'h2 : 2'h0;
      end
   end

   // Control, page and offset registers; start clears itself on completion
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctrl_q <= FRPE_CTRL_RST;
         page_q <= 8'h00;
         offs_q <= 16'h0000;
      end else begin
         // A start in the completion cycle wins, so the new cycle keeps its flag
         if (start_ok) begin
            ctrl_q[FRPE_START_BIT] <= 1'b1;
            ctrl_q[FRPE_ERR_BIT]   <= 1'b0;
         end else if (t_done) begin
            ctrl_q[FRPE_START_BIT] <= 1'b0;
         end
         if (start_bad) begin
            ctrl_q[FRPE_ERR_BIT] <= 1'b1;
         end
         if (ctrl_wr_cfg) begin
            ctrl_q[FRPE_OP_LSB +: FRPE_OP_W] <= op;
            ctrl_q[FRPE_ERASE_BIT]           <= wdat[FRPE_ERASE_BIT];
            ctrl_q[FRPE_PROGRAM_WRITE_ENABLE_BIT]            <= wdat[FRPE_PROGRAM_WRITE_ENABLE_BIT];
         end
         if (wr && hit_page && !t_busy) page_q <= wdat[7:0];
         if (wr && hit_offs && !t_busy) offs_q <= wdat;
      end
   end

   // Flash command and stall; the stall covers the whole timed cycle
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         stall_q     <= 1'b0;
         erase_q     <= 1'b0;
         row_q       <= 1'b0;
         faddr_q     <= 24'h000000;
         fidx_q      <= 6'h00;
         fdata_q     <= '0;
         fvld_q      <= 1'b0;
         streaming_q <= 1'b0;
      end else begin
         erase_q <= start_ok & op_erase;
         row_q   <= start_ok & op_row;
         if (start_ok) begin
            stall_q     <= 1'b1;
            faddr_q     <= op_erase ? blk : rowa;
            fidx_q      <= 6'h00;
            streaming_q <= op_row;
         end else if (t_done) begin
            stall_q <= 1'b0;
         end
         // Row data streams out one instruction per clock
         fvld_q <= streaming_q;
         if (streaming_q) begin
            fdata_q <= hold_mem[fidx_q];
            fidx_q  <= fidx_q + 6'h01;
            if (fidx_q == 6'(ROW_WORDS - 1)) streaming_q <= 1'b0;
         end
      end
   end

   assign o_avs_readdata    = rdata_q;
   assign o_avs_waitrequest = ~ack_q;
   assign o_avs_response    = resp_q;
   assign o_cpu_stall       = stall_q;
   assign o_flash_erase     = erase_q;
   assign o_flash_row       = row_q;
   assign o_flash_addr      = faddr_q;
   assign o_flash_idx       = fidx_q;
   assign o_flash_data      = fdata_q;
   assign o_flash_data_vld  = fvld_q;

   stall_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      ctrl_q[FRPE_START_BIT] |-> o_cpu_stall || $past(start_ok))
      else $error("start set without stall");
   start_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      t_done && !start_ok |=> !ctrl_q[FRPE_START_BIT])
      else $error("start bit not cleared");
   locked_start_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      start_req && !armed |=> !o_flash_erase && !o_flash_row)
      else $error("flash started while locked");
   bad_flag_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      start_bad |=> ctrl_q[FRPE_ERR_BIT] && !o_cpu_stall)
      else $error("refused start not flagged");
   erase_code_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      o_flash_erase |-> $past(op) == FRPE_OP_ERASE && o_flash_addr[9:0] == 10'h000)
      else $error("erase with wrong code or address");
   row_stream_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      o_flash_row |=> ##1 o_flash_data_vld [*8])
      else $error("row data not streamed");
   row_code_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      o_flash_row |-> $past(op) == FRPE_OP_ROW && o_flash_addr[6:0] == 7'h00)
      else $error("row program misaligned");
   start_stall_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      start_ok |=> o_cpu_stall [*4])
      else $error("stall dropped early");
endmodule
`default_nettype wire

// file: verif/frpe_tb.sv
// Directed bench for the flash sequencer: bus tasks and call sequences.
// Assumes frpe_top with shortened cycle counts on one 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import frpe_pkg::*;
   localparam int EC = 20;
   localparam int RC = 10;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [3:0]  be = 4'hF;
   logic        bw = 1'b0;
   logic [5:0]  bi = 6'h0;
   logic [23:0] bd = 24'h0;
   wire logic [31:0] rdat;
   wire logic        wait_r;
   wire logic [1:0]  resp;
   wire logic        stall;
   wire logic        fer;
   wire logic        frow;
   wire logic [23:0] faddr;
   wire logic [5:0]  fidx;
   wire logic [23:0] fdat;
   wire logic        fvld;
   int          n_mismatch = 0;
   int          samples_checked = 0;
   int          stall_n = 0;
   int          er_n = 0;
   int          row_n = 0;
   int          vld_n = 0;
   logic [31:0] got;
   logic [1:0]  rsp;
   logic [23:0] ea = 24'h0;
   logic [23:0] mem [64];

   // Short counts keep the run brief; expectations use EC and RC
   frpe_top #(.ERASE_CYC(EC), .ROW_CYC(RC)) dut (
      .i_ref_clk(clk), .i_reset_n(rst_n), .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
      .i_buf_wr(bw), .i_buf_idx(bi), .i_buf_data(bd), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wait_r), .o_avs_response(resp), .o_cpu_stall(stall),
      .o_flash_erase(fer), .o_flash_row(frow), .o_flash_addr(faddr),
      .o_flash_idx(fidx), .o_flash_data(fdat), .o_flash_data_vld(fvld));

   always #50 clk = ~clk;

   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD t=%0t %s got %h exp %h", $time, m, g, e);
      end
   endtask

   // Request held until waitrequest is sampled low; bounded wait
   task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] b);
      int k;
      k = 0;
      @(posedge clk);
      adr <= a;
      wd <= d;
      be <= b;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk);
         k++;
      end while (wait_r !== 1'b0 && k < 50);
      got = rdat;
      rsp = resp;
      wr <= 1'b0;
      rd <= 1'b0;
      if (k >= 50) chk(32'h0, 32'h1, "no bus answer");
   endtask

   task automatic w(input logic [3:0] a, input logic [31:0] d);
      acc(1'b1, a, d, 4'hF);
   endtask

   task automatic r(input logic [3:0] a);
      acc(1'b0, a, 32'h0, 4'hF);
   endtask

   // Waits out the stall, then the 64-word tail of a row transfer
   task automatic wait_idle();
      int k;
      k = 0;
      while (stall !== 1'b0 && k < 500) begin
         @(posedge clk);
         k++;
      end
      repeat (70) @(posedge clk);
   endtask

   // Watches flash commands; row words must arrive in index order
   always @(posedge clk) begin
      if (stall === 1'b1) stall_n++;
      if (fer === 1'b1) begin
         er_n++;
         chk(32'(faddr), 32'(ea), "erase addr");
      end
      if (frow === 1'b1) begin
         row_n++;
         chk(32'(faddr), 32'(ea), "row addr");
      end
      if (fvld === 1'b1) begin
         // The index has already stepped past the word on the data lines
         chk(32'({fidx, fdat}), 32'({6'(vld_n + 1), mem[vld_n[5:0]]}), "row word");
         vld_n++;
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Whole run is a few hundred cycles; the limit of 20000 cycles is over fifty times that
   initial begin
      #(100 * 20000);
      n_mismatch++;
      report_and_stop();
   end

   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 64; i++) begin
         @(posedge clk);
         mem[i] = 24'h5A0000 + 24'(i * 3);
         bw <= 1'b1;
         bi <= i[5:0];
         bd <= 24'h5A0000 + 24'(i * 3);
      end
      @(posedge clk);
      bw <= 1'b0;
      r(FRPE_CTRL_OFS);
      chk(got, 32'(FRPE_CTRL_RST), "ctrl reset");
      r(FRPE_KEY_OFS);
      chk(got, 32'h0, "key reads zero");
      r(4'h2);
      chk(32'(rsp), 32'h2, "unmapped response");
      acc(1'b1, FRPE_PAGE_OFS, 32'h77, 4'h0);
      r(FRPE_PAGE_OFS);
      chk(got, 32'h0, "masked write");
      w(FRPE_PAGE_OFS, 32'h12);
      w(FRPE_OFFS_OFS, 32'h3400);
      ea = 24'h123400;
      // Refused starts: no key, broken key, erase without erase bit, row with erase bit, no enable
      w(FRPE_CTRL_OFS, 32'h4042);
      w(FRPE_CTRL_OFS, 32'hC042);
      r(FRPE_CTRL_OFS);
      chk(got & 32'hA000, 32'h2000, "start without key");
      w(FRPE_KEY_OFS, 32'h55);
      w(FRPE_PAGE_OFS, 32'h12);
      w(FRPE_KEY_OFS, 32'hAA);
      w(FRPE_CTRL_OFS, 32'hC042);
      w(FRPE_KEY_OFS, 32'h55);
      w(FRPE_KEY_OFS, 32'hAA);
      w(FRPE_CTRL_OFS, 32'hC002);
      w(FRPE_KEY_OFS, 32'h55);
      w(FRPE_KEY_OFS, 32'hAA);
      w(FRPE_CTRL_OFS, 32'hC041);
      w(FRPE_KEY_OFS, 32'h55);
      w(FRPE_KEY_OFS, 32'hAA);
      w(FRPE_CTRL_OFS, 32'h8042);
      chk(32'(stall_n + er_n + row_n), 32'h0, "refused starts");
      // Block erase; a repeated first key restarts the sequence
      w(FRPE_KEY_OFS, 32'h55);
      w(FRPE_KEY_OFS, 32'h55);
      w(FRPE_KEY_OFS, 32'hAA);
      w(FRPE_CTRL_OFS, 32'hC042);
      r(FRPE_CTRL_OFS);
      chk({got[15], 30'h0, stall}, 32'h80000001, "erase running");
      wait_idle();
      chk(32'(stall_n), 32'(EC + 1), "erase stall length");
      chk(32'(er_n), 32'h1, "one erase");
      r(FRPE_CTRL_OFS);
      chk(got & 32'h800F, 32'h0002, "erase start cleared");
      // Row program; a read between keys keeps the sequence
      stall_n = 0;
      w(FRPE_OFFS_OFS, 32'h0080);
      ea = 24'h120080;
      w(FRPE_CTRL_OFS, 32'h4001);
      w(FRPE_KEY_OFS, 32'h55);
      r(FRPE_CTRL_OFS);
      w(FRPE_KEY_OFS, 32'hAA);
      w(FRPE_CTRL_OFS, 32'hC001);
      w(FRPE_PAGE_OFS, 32'h55);
      wait_idle();
      chk(32'(stall_n), 32'(RC + 1), "row stall length");
      chk(32'(row_n), 32'h1, "one row");
      chk(32'(vld_n), 32'(FRPE_ROW_WORDS), "row word count");
      r(FRPE_CTRL_OFS);
      chk(got & 32'h800F, 32'h0001, "row start cleared");
      r(FRPE_PAGE_OFS);
      chk(got, 32'h12, "page held while busy");
      report_and_stop();
   end
endmodule
`default_nettype wire
